/* verilog/acfsc_top.sv */
// APB register block: conversion complete flags, special channel select, test registers
`timescale 1ns/1ps
`default_nettype none
`include "acfsc_cfg.svh"

module acfsc_top #(
  parameter int NCH  = `ACFSC_NUM_CHAN,
  parameter int RESW = `ACFSC_RES_W
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                special_mode,
  input  wire logic                conv_done,
  input  wire logic [3:0]          conv_pos,
  input  wire logic [NCH*RESW-1:0] result_bank,
  output logic                     seq_start,
  output logic [3:0]               chan_sel,
  output logic                     special_sel,
  output acfsc_pkg::acfsc_ref_t    ref_sel,
  output logic                     chan_reserved,
  output logic [NCH-1:0]           result_read,
  output logic                     irq
);
  import acfsc_pkg::*;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  acfsc_bus_state_t       bus_state_r;
  logic [31:0]            prdata_r;
  logic                   pslverr_r;
  logic [7:0]             test0_r;
  logic [7:0]             test1_r;
  logic [3:0]             chan_sel_r;
  logic                   fast_clr_r;
  logic [`ACFSC_IRQ_W-1:0] irq_stat_r;
  logic [`ACFSC_IRQ_W-1:0] irq_mask_r;
  logic                   irq_r;
  logic                   seq_start_r;
  logic                   special_sel_r;
  acfsc_ref_t             ref_sel_r;
  logic                   chan_reserved_r;
  logic [NCH-1:0]         result_read_r;

  acfsc_flag_if #(.N(NCH)) fif ();

  acfsc_flags #(.N(NCH)) u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .fif     (fif)
  );

  // ---------------------------------------------------------------
  // Channel decode
  // ---------------------------------------------------------------
  // Returns {reserved, special, ref} for a select code under the enable
  function automatic logic [3:0] chan_decode(input logic en, input logic [3:0] code);
    logic [3:0] r;
    r = {1'b0, 1'b0, ACFSC_REF_NONE};
    if (en) begin
      if (code[3:2] == 2'b01 && code[1:0] != 2'b11) begin
        r = {1'b0, 1'b1, code[1:0]};
      end else begin
        r = {1'b1, 1'b1, ACFSC_REF_NONE};
      end
    end
    return r;
  endfunction

  wire        special_en = test1_r[`ACFSC_BIT_SPECIAL_EN];
  wire [3:0]  dec_now    = chan_decode(special_en, chan_sel_r);

  // ---------------------------------------------------------------
  // APB address decode
  // ---------------------------------------------------------------
  wire        acc        = psel & penable;
  wire        fire       = acc & (bus_state_r == ACFSC_BUS_DONE);
  wire        wr_fire    = fire & pwrite;
  wire        rd_fire    = fire & ~pwrite;
  wire        hit_test0  = paddr == `ACFSC_OFF_TEST0;
  wire        hit_test1  = paddr == `ACFSC_OFF_TEST1;
  wire        hit_hi     = paddr == `ACFSC_OFF_FLAGS_HI;
  wire        hit_lo     = paddr == `ACFSC_OFF_FLAGS_LO;
  wire        hit_seq    = paddr == `ACFSC_OFF_SEQ_CTL;
  wire        hit_fctl   = paddr == `ACFSC_OFF_FLAG_CTL;
  wire        hit_istat  = paddr == `ACFSC_OFF_IRQ_STAT;
  wire        hit_imask  = paddr == `ACFSC_OFF_IRQ_MASK;
  wire        hit_res    = (paddr >= `ACFSC_OFF_RES_BASE) && (paddr <= `ACFSC_OFF_RES_LAST)
                           && (paddr[1:0] == 2'b00);
  wire [3:0]  res_idx    = paddr[5:2];
  wire        mapped     = hit_test0 | hit_test1 | hit_hi | hit_lo | hit_seq | hit_fctl
                           | hit_istat | hit_imask | hit_res;
  wire        lane0      = pstrb[0];

  // ---------------------------------------------------------------
  // Read data selection
  // ---------------------------------------------------------------
  wire [RESW-1:0] res_word = result_bank[res_idx*RESW +: RESW];
  wire [31:0] rd_test0 = {24'h000000, test0_r};
  wire [31:0] rd_test1 = {24'h000000, test1_r};
  wire [31:0] rd_hi    = {24'h000000, fif.flags[15:8]};
  wire [31:0] rd_lo    = {24'h000000, fif.flags[7:0]};
  wire [31:0] rd_seq   = {28'h0000000, chan_sel_r};
  wire [31:0] rd_fctl  = {31'h00000000, fast_clr_r};
  wire [31:0] rd_istat = {30'h00000000, irq_stat_r};
  wire [31:0] rd_imask = {30'h00000000, irq_mask_r};
  wire [31:0] rd_res   = {{(32-RESW){1'b0}}, res_word};
  wire [31:0] rd_mux   = hit_test0 ? rd_test0 :
                         hit_test1 ? rd_test1 :
                         hit_hi    ? rd_hi    :
                         hit_lo    ? rd_lo    :
                         hit_seq   ? rd_seq   :
                         hit_fctl  ? rd_fctl  :
                         hit_istat ? rd_istat :
                         hit_imask ? rd_imask :
                         hit_res   ? rd_res   : 32'h00000000;

  // ---------------------------------------------------------------
  // Flag bank hookup
  // ---------------------------------------------------------------
  wire        seq_wr     = wr_fire & hit_seq;
  wire [15:0] pos_onehot = 16'h0001 << conv_pos;

  assign fif.set_vec    = conv_done ? pos_onehot[NCH-1:0] : {NCH{1'b0}};
  assign fif.seq_clr    = seq_wr;
  assign fif.rd_stat_lo = rd_fire & hit_lo;
  assign fif.rd_stat_hi = rd_fire & hit_hi;
  assign fif.fast_clr   = fast_clr_r;
  assign fif.rd_res_vec = (rd_fire & hit_res) ? (16'h0001 << res_idx) : {NCH{1'b0}};

  // ---------------------------------------------------------------
  // Interrupt events
  // ---------------------------------------------------------------
  wire [`ACFSC_IRQ_W-1:0] irq_evt = {chan_reserved_r & seq_start_r, conv_done};
  wire [`ACFSC_IRQ_W-1:0] irq_w1c = (wr_fire & hit_istat & lane0)
                                    ? pwdata[`ACFSC_IRQ_W-1:0] : {`ACFSC_IRQ_W{1'b0}};
  // Event set wins over a same-cycle write-one clear
  wire [`ACFSC_IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~irq_w1c) | irq_evt;

  // ---------------------------------------------------------------
  // Bus handshake: one wait cycle so read data comes from a flop
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state_r <= ACFSC_BUS_IDLE;
      prdata_r    <= 32'h00000000;
      pslverr_r   <= 1'b0;
    end else begin
      case (bus_state_r)
        ACFSC_BUS_IDLE: begin
          if (acc) begin
            bus_state_r <= ACFSC_BUS_DONE;
            prdata_r    <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_r   <= ~mapped;
          end
        end
        ACFSC_BUS_DONE: begin
          bus_state_r <= ACFSC_BUS_IDLE;
          pslverr_r   <= 1'b0;
        end
        default: begin
          bus_state_r <= ACFSC_BUS_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test0_r    <= `ACFSC_RST_BYTE;
      test1_r    <= `ACFSC_RST_BYTE;
      chan_sel_r <= 4'h0;
      fast_clr_r <= 1'b0;
      irq_mask_r <= {`ACFSC_IRQ_W{1'b0}};
    end else begin
      // Normal mode leaves this register unimplemented for writes
      if (wr_fire & hit_test0 & lane0 & special_mode) begin
        test0_r <= pwdata[7:0];
      end
      if (wr_fire & hit_test1 & lane0) begin
        test1_r <= pwdata[7:0];
      end
      if (seq_wr & lane0) begin
        chan_sel_r <= pwdata[3:0];
      end
      if (wr_fire & hit_fctl & lane0) begin
        fast_clr_r <= pwdata[`ACFSC_BIT_FAST_CLR];
      end
      if (wr_fire & hit_imask & lane0) begin
        irq_mask_r <= pwdata[`ACFSC_IRQ_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Status, interrupt and outputs toward the converter
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r      <= {`ACFSC_IRQ_W{1'b0}};
      irq_r           <= 1'b0;
      seq_start_r     <= 1'b0;
      special_sel_r   <= 1'b0;
      ref_sel_r       <= ACFSC_REF_NONE;
      chan_reserved_r <= 1'b0;
      result_read_r   <= {NCH{1'b0}};
    end else begin
      irq_stat_r      <= irq_stat_nxt;
      irq_r           <= |(irq_stat_nxt & irq_mask_r);
      seq_start_r     <= seq_wr;
      special_sel_r   <= dec_now[2];
      ref_sel_r       <= acfsc_ref_t'(dec_now[1:0]);
      chan_reserved_r <= dec_now[3];
      result_read_r   <= fif.rd_res_vec;
    end
  end

  assign prdata        = prdata_r;
  assign pready        = bus_state_r == ACFSC_BUS_DONE;
  assign pslverr       = pslverr_r;
  assign seq_start     = seq_start_r;
  assign chan_sel      = chan_sel_r;
  assign special_sel   = special_sel_r;
  assign ref_sel       = ref_sel_r;
  assign chan_reserved = chan_reserved_r;
  assign result_read   = result_read_r;
  assign irq           = irq_r;
endmodule

`default_nettype wire

/* verilog/acfsc_cfg.svh */
// Register offsets, field positions, reset values and sizes of the completion flag block
`ifndef ACFSC_CFG_SVH
`define ACFSC_CFG_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ACFSC_OFF_TEST0     12'h000
`define ACFSC_OFF_TEST1     12'h004
`define ACFSC_OFF_FLAGS_HI  12'h008
`define ACFSC_OFF_FLAGS_LO  12'h00c
`define ACFSC_OFF_SEQ_CTL   12'h010
`define ACFSC_OFF_FLAG_CTL  12'h014
`define ACFSC_OFF_IRQ_STAT  12'h018
`define ACFSC_OFF_IRQ_MASK  12'h01c
`define ACFSC_OFF_RES_BASE  12'h040
`define ACFSC_OFF_RES_LAST  12'h07c

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ACFSC_BIT_SPECIAL_EN  0
`define ACFSC_BIT_FAST_CLR    0
`define ACFSC_BIT_IRQ_CONV    0
`define ACFSC_BIT_IRQ_RSVD    1

// ---------------------------------------------------------------
// Reset values and sizes
// ---------------------------------------------------------------
`define ACFSC_RST_BYTE     8'h00
`define ACFSC_RST_FLAGS    16'h0000
`define ACFSC_IRQ_W        2
`define ACFSC_NUM_CHAN     16
`define ACFSC_RES_W        10

`endif

/* verilog/acfsc_pkg.sv */
// Types shared by the completion flag block
package acfsc_pkg;

  typedef enum logic [0:0] {
    ACFSC_BUS_IDLE = 1'b0,
    ACFSC_BUS_DONE = 1'b1
  } acfsc_bus_state_t;

  typedef enum logic [1:0] {
    ACFSC_REF_HIGH = 2'b00,
    ACFSC_REF_LOW  = 2'b01,
    ACFSC_REF_MID  = 2'b10,
    ACFSC_REF_NONE = 2'b11
  } acfsc_ref_t;

endpackage

/* verilog/acfsc_flag_if.sv */
// Signals between the bus side and the completion flag bank
`timescale 1ns/1ps
`default_nettype none

interface acfsc_flag_if #(
  parameter int N = 16
);
  logic [N-1:0] set_vec;
  logic [N-1:0] rd_res_vec;
  logic         seq_clr;
  logic         rd_stat_lo;
  logic         rd_stat_hi;
  logic         fast_clr;
  logic [N-1:0] flags;

  modport ctrl (
    output set_vec,
    output rd_res_vec,
    output seq_clr,
    output rd_stat_lo,
    output rd_stat_hi,
    output fast_clr,
    input  flags
  );

  modport bank (
    input  set_vec,
    input  rd_res_vec,
    input  seq_clr,
    input  rd_stat_lo,
    input  rd_stat_hi,
    input  fast_clr,
    output flags
  );
endinterface

`default_nettype wire

/* verilog/acfsc_flags.sv */
// Bank of conversion complete flags with their read-based clear tracking
`timescale 1ns/1ps
`default_nettype none

module acfsc_flags #(
  parameter int N = 16
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  acfsc_flag_if.bank  fif
);
  import acfsc_pkg::*;

  logic [N-1:0] flag_r;
  logic [N-1:0] arm_r;
  logic [N-1:0] flag_nxt;
  logic [N-1:0] arm_nxt;

  assign fif.flags = flag_r;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_flag
      // Low half is seen through the low status register, high half through the high one
      wire stat_rd = (i < N/2) ? fif.rd_stat_lo : fif.rd_stat_hi;
      // Without fast clear the status read must come first; it arms the flag
      wire rd_clr  = fif.rd_res_vec[i] & (fif.fast_clr | arm_r[i]);
      assign flag_nxt[i] = fif.seq_clr    ? 1'b0 :
                           fif.set_vec[i] ? 1'b1 :
                           rd_clr         ? 1'b0 : flag_r[i];
      assign arm_nxt[i]  = fif.seq_clr           ? 1'b0 :
                           (stat_rd & flag_r[i]) ? 1'b1 :
                           rd_clr                ? 1'b0 : arm_r[i];
    end
  endgenerate

  // One process owns both vectors so no bit has two writers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= {N{1'b0}};
      arm_r  <= {N{1'b0}};
    end else begin
      flag_r <= flag_nxt;
      arm_r  <= arm_nxt;
    end
  end
endmodule

`default_nettype wire

/* bench/acfsc_properties.sv */
// Concurrent checks on the ports of the completion flag block
`timescale 1ns/1ps
`default_nettype none

module acfsc_properties
  import acfsc_pkg::*;
#(
  parameter int NCH = 16
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [3:0]      pstrb,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            seq_start,
  input wire logic [3:0]      chan_sel,
  input wire logic            special_sel,
  input wire acfsc_ref_t      ref_sel,
  input wire logic            chan_reserved,
  input wire logic [NCH-1:0]  result_read
);
  // ---------------------------------------------------------------
  // Decode of completed transfers
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire           done    = psel && penable && pready;
  wire           wr_seq  = done && pwrite && pstrb[0] && paddr == 12'h010;
  wire           rd_res  = done && !pwrite && paddr[11:6] == 6'h01;
  wire [NCH-1:0] res_vec = rd_res ? NCH'(1) << paddr[5:2] : '0;
  logic [3:0]    prev_chan_r;
  // Selection outputs lag chan_sel by one cycle, so compare with the old code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prev_chan_r <= 4'h0;
    else prev_chan_r <= chan_sel;
  end
  wire           rsv     = !(prev_chan_r[3:2] == 2'b01 && prev_chan_r[1:0] != 2'b11);

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_wait_state;
    psel && penable && !$past(penable) |-> !pready ##1 pready;
  endproperty
  a_wait_state: assert property (p_wait_state)
    else $error("access phase not answered after one wait state");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error flag without ready");
  property p_seq_pulse;
    seq_start == $past(wr_seq);
  endproperty
  a_seq_pulse: assert property (p_seq_pulse)
    else $error("sequence start pulse does not follow the control write");
  property p_chan_sel;
    wr_seq |=> chan_sel == $past(pwdata[3:0]);
  endproperty
  a_chan_sel: assert property (p_chan_sel)
    else $error("channel select not taken from the control write");
  property p_res_pulse;
    result_read == $past(res_vec);
  endproperty
  a_res_pulse: assert property (p_res_pulse)
    else $error("result read pulse has the wrong index or moment");
  property p_ref_map;
    special_sel |-> chan_reserved == rsv
      && ref_sel == (rsv ? ACFSC_REF_NONE : acfsc_ref_t'(prev_chan_r[1:0]));
  endproperty
  a_ref_map: assert property (p_ref_map)
    else $error("special channel code decoded wrongly");
  property p_no_special;
    !special_sel |-> ref_sel == ACFSC_REF_NONE && !chan_reserved;
  endproperty
  a_no_special: assert property (p_no_special)
    else $error("internal channel chosen while special channels are off");
  property p_reset_vals;
    $rose(presetn) |-> !seq_start && !special_sel && result_read == '0
      && ref_sel == ACFSC_REF_NONE;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("outputs not at reset values after reset");
endmodule

bind acfsc_top acfsc_properties #(.NCH(NCH)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .seq_start(seq_start), .chan_sel(chan_sel), .special_sel(special_sel),
  .ref_sel(ref_sel), .chan_reserved(chan_reserved), .result_read(result_read)
);

`default_nettype wire

/* bench/adc_complete_flags_special_chan_bench.sv */
// Self-checking bench of the completion flag block
`timescale 1ns/1ps
`default_nettype none
`include "acfsc_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end

module adc_complete_flags_special_chan_bench;
  import acfsc_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, special_mode, conv_done;
  logic         pready, pslverr, seq_start, special_sel, chan_reserved, irq, er;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [3:0]   pstrb, conv_pos, chan_sel;
  logic [159:0] result_bank;
  logic [15:0]  result_read, ex;
  logic [7:0]   v;
  acfsc_ref_t   ref_sel;
  int           miscompares, total_checks, p;

  acfsc_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .special_mode(special_mode), .conv_done(conv_done),
    .conv_pos(conv_pos), .result_bank(result_bank), .seq_start(seq_start),
    .chan_sel(chan_sel), .special_sel(special_sel), .ref_sel(ref_sel),
    .chan_reserved(chan_reserved), .result_read(result_read), .irq(irq)
  );

  // ---------------------------------------------------------------
  // Expectations and bus tasks
  // ---------------------------------------------------------------
  function automatic logic rsv(input logic [3:0] c);
    return !(c[3:2] == 2'b01 && c[1:0] != 2'b11);
  endfunction
  function automatic acfsc_ref_t ref_of(input logic [3:0] c);
    return rsv(c) ? ACFSC_REF_NONE : acfsc_ref_t'(c[1:0]);
  endfunction
  task automatic stop_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // A conversion index cp >= 0 is pulsed so it lands on the completion edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input int cp);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Pulse raised here is seen by the design at the completing edge
    if (cp >= 0) begin
      conv_done <= 1'b1;
      conv_pos <= 4'(cp);
    end
    // Ready is sampled at rising edges only; data are taken at that same edge
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    conv_done <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, -1);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    apb(1'b0, a, 8'h00, -1);
    `CHK(rd[7:0] & m, e & m)
  endtask
  task automatic rdres(input int i, input int cp);
    apb(1'b0, 12'h040 + 12'(4 * i), 8'h00, cp);
    `CHK(rd[9:0], result_bank[i*10 +: 10])
  endtask
  task automatic conv(input int c);
    @(posedge pclk);
    conv_done <= 1'b1;
    conv_pos <= 4'(c);
    @(posedge pclk);
    conv_done <= 1'b0;
  endtask
  task automatic gap();
    repeat (3) @(negedge pclk);
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and scenarios
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // The scenarios need a few hundred cycles; this span is far beyond that
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end
  initial begin
    void'($urandom(50658));
    {presetn, psel, penable, pwrite, special_mode, conv_done} = '0;
    {paddr, pwdata, conv_pos} = '0;
    pstrb = 4'hf;
    for (int i = 0; i < 160; i++) result_bank[i] = 1'($urandom);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`ACFSC_OFF_FLAGS_LO, 8'h00);
    rdc(`ACFSC_OFF_FLAGS_HI, 8'h00);
    rdc(`ACFSC_OFF_TEST1, 8'h00, 8'h3f);
    v = 8'($urandom) | 8'h01;
    wr(`ACFSC_OFF_TEST0, v);
    rdc(`ACFSC_OFF_TEST0, 8'h00);
    special_mode <= 1'b1;
    wr(`ACFSC_OFF_TEST0, v);
    rdc(`ACFSC_OFF_TEST0, v);
    special_mode <= 1'b0;
    wr(`ACFSC_OFF_TEST1, ~v);
    rdc(`ACFSC_OFF_TEST1, ~v, 8'h3f);
    wr(`ACFSC_OFF_TEST1, 8'h01);
    for (int c = 0; c < 16; c++) begin
      wr(`ACFSC_OFF_SEQ_CTL, 8'(c));
      gap();
      `CHK(chan_sel, 4'(c))
      `CHK({chan_reserved, ref_sel}, {rsv(4'(c)), ref_of(4'(c))})
    end
    rdc(`ACFSC_OFF_IRQ_STAT, 8'h02, 8'h03);
    wr(`ACFSC_OFF_TEST1, 8'h00);
    gap();
    `CHK({chan_reserved, ref_sel}, {1'b0, ACFSC_REF_NONE})
    wr(`ACFSC_OFF_IRQ_STAT, 8'h03);
    wr(`ACFSC_OFF_SEQ_CTL, 8'h00);
    ex = 16'h8101;
    conv(0);
    conv(8);
    conv(15);
    repeat (4) begin
      p = $urandom_range(14, 1);
      conv(p);
      ex[p] = 1'b1;
    end
    // Result read without a status read first must not clear
    rdres(0, -1);
    rdc(`ACFSC_OFF_FLAGS_LO, ex[7:0]);
    rdc(`ACFSC_OFF_FLAGS_HI, ex[15:8]);
    wr(`ACFSC_OFF_FLAGS_LO, 8'h00);
    wr(`ACFSC_OFF_FLAGS_HI, 8'h00);
    rdc(`ACFSC_OFF_FLAGS_LO, ex[7:0]);
    rdres(0, -1);
    rdres(8, -1);
    ex[0] = 1'b0;
    ex[8] = 1'b0;
    rdc(`ACFSC_OFF_FLAGS_LO, ex[7:0]);
    rdc(`ACFSC_OFF_FLAGS_HI, ex[15:8]);
    wr(`ACFSC_OFF_FLAG_CTL, 8'h01);
    rdres(3, -1);
    ex[3] = 1'b0;
    rdres(15, 15);
    rdc(`ACFSC_OFF_FLAGS_LO, ex[7:0]);
    rdc(`ACFSC_OFF_FLAGS_HI, ex[15:8]);
    apb(1'b1, `ACFSC_OFF_SEQ_CTL, 8'h00, 5);
    rdc(`ACFSC_OFF_FLAGS_LO, 8'h00);
    rdc(`ACFSC_OFF_FLAGS_HI, 8'h00);
    wr(`ACFSC_OFF_IRQ_MASK, 8'h01);
    conv(2);
    gap();
    `CHK(irq, 1'b1)
    wr(`ACFSC_OFF_IRQ_STAT, 8'h01);
    gap();
    `CHK(irq, 1'b0)
    wr(`ACFSC_OFF_IRQ_MASK, 8'h00);
    conv(4);
    rdc(`ACFSC_OFF_IRQ_STAT, 8'h01, 8'h01);
    `CHK(irq, 1'b0)
    apb(1'b0, 12'h020, 8'h00, -1);
    `CHK({er, rd}, {1'b1, 32'h0})
    stop_test();
  end
endmodule

`default_nettype wire
